// File: lpac_partner_ability.sv
// partner ability register (base page and next page views) at address 05h
// Notes on behaviour
// - the partner's advertised ability word is readable at address 05h.
// - with next pages supported, a next page received after base negotiation replaces the contents.
// - bit 15 shows the partner's next-page request, resets to 0, read-only.
// - bit 14 follows the negotiation engine's acknowledge decoded from incoming bursts.
// - bit 13 shows the partner's remote fault, resets to 0.
// - bit 12 is reserved and reads 0 in the base page view.
// - bit 11 shows partner asymmetric pause support.
// - bit 10 shows partner symmetric pause support.
// - bit 9 shows partner 100BASE-T4 ability.
// - bit 8 shows partner 100BASE-TX full duplex ability.
// - bit 7 shows partner 100BASE-TX ability.
// - bit 6 shows partner 10BASE-T full duplex ability.
// - bit 5 shows partner 10BASE-T ability.
// - bits 4 to 0 hold the partner's protocol selector, resetting to zero.
// - in the next page view bits 10 to 0 carry the code, message page when bit 13 is set.
`timescale 1ns/1ps
module lpac_partner_ability (
    input  wire logic                               i_clk,
    input  wire logic                               i_rst,
    input  wire logic                               i_ce,
    input  wire logic                               i_np_supported,
    input  wire logic                               i_base_valid,
    input  wire logic [lpac_pkg::LPAC_DATA_W-1:0]   i_base_word,
    input  wire logic                               i_an_complete,
    input  wire logic                               i_next_valid,
    input  wire logic [lpac_pkg::LPAC_DATA_W-1:0]   i_next_word,
    input  wire logic                               i_ack_seen,
    input  wire logic                               i_mgmt_rd,
    input  wire logic                               i_mgmt_wr,
    input  wire logic [lpac_pkg::LPAC_ADDR_W-1:0]   i_mgmt_addr,
    input  wire logic [lpac_pkg::LPAC_DATA_W-1:0]   i_mgmt_wdata,
    output logic      [lpac_pkg::LPAC_DATA_W-1:0]   o_mgmt_rdata,
    output logic                                    o_mgmt_rvalid,
    output logic      [lpac_pkg::LPAC_DATA_W-1:0]   o_partner_ability_register,
    output logic                                    o_partner_next_page,
    output logic                                    o_partner_remote_fault,
    output logic                                    o_partner_message_page_flag,
    output logic                                    o_next_page_view
);
    import lpac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic hit(input logic [LPAC_ADDR_W-1:0] addr);
        hit = (addr == LPAC_PARTNER_ABILITY_ADDR);
    endfunction

    logic [LPAC_DATA_W-1:0] word_reg;
    logic [LPAC_DATA_W-1:0] word_next;
    lpac_view_t             view_reg;
    lpac_view_t             view_next;
    logic                   ack_reg;
    logic                   an_done_reg;

    ////////////////////////////////////////////////////////////////////////////
    // capture from the negotiation engine

    always_comb begin
        word_next = word_reg;
        view_next = view_reg;
        case (view_reg)
            LPAC_VIEW_EMPTY, LPAC_VIEW_BASE: begin
                if (i_base_valid) begin
                    // reserved bit forced low whatever the partner sent
                    word_next = i_base_word & LPAC_BASE_MASK;
                    view_next = LPAC_VIEW_BASE;
                end
            end
            LPAC_VIEW_NEXT: begin
                if (i_base_valid) begin
                    // a fresh base page means negotiation restarted
                    word_next = i_base_word & LPAC_BASE_MASK;
                    view_next = LPAC_VIEW_BASE;
                end
            end
            default: begin
                view_next = LPAC_VIEW_EMPTY;
            end
        endcase
        // next pages only land once the base exchange has completed
        if (!i_base_valid && i_next_valid && i_np_supported && an_done_reg) begin
            word_next = i_next_word & LPAC_NEXT_MASK;
            view_next = LPAC_VIEW_NEXT;
        end
        // acknowledge bit tracks the engine level, not the captured page
        word_next = (word_next & ~LPAC_ACK_MASK) | ({LPAC_DATA_W{ack_reg}} & LPAC_ACK_MASK);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            word_reg <= LPAC_RESET_VALUE;
            view_reg <= LPAC_VIEW_EMPTY;
        end else if (i_ce) begin
            word_reg <= word_next;
            view_reg <= view_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_reg     <= 1'b0;
            an_done_reg <= 1'b0;
        end else if (i_ce) begin
            ack_reg <= i_ack_seen;
            if (i_base_valid) begin
                an_done_reg <= 1'b0;
            end else if (i_an_complete) begin
                an_done_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // management access; writes deliberately have no path into word_reg

    logic                   wr_unused;
    logic [LPAC_DATA_W-1:0] wdata_unused;
    assign wr_unused    = i_mgmt_wr;
    assign wdata_unused = i_mgmt_wdata;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_mgmt_rdata  <= LPAC_RESET_VALUE;
            o_mgmt_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_mgmt_rvalid <= i_mgmt_rd;
            if (i_mgmt_rd && hit(i_mgmt_addr)) begin
                o_mgmt_rdata <= word_reg;
            end else begin
                o_mgmt_rdata <= LPAC_RESET_VALUE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoded status outputs

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_partner_ability_register  <= LPAC_RESET_VALUE;
            o_partner_next_page         <= 1'b0;
            o_partner_remote_fault      <= 1'b0;
            o_partner_message_page_flag <= 1'b0;
            o_next_page_view            <= 1'b0;
        end else if (i_ce) begin
            o_partner_ability_register <= word_next;
            o_partner_next_page        <= word_next[LPAC_BIT_NEXT_PAGE];
            o_next_page_view           <= (view_next == LPAC_VIEW_NEXT);
            // bit 13 means remote fault on base page, message page on next page
            o_partner_remote_fault      <= (view_next != LPAC_VIEW_NEXT) && word_next[LPAC_BIT_REMOTE_FAULT];
            o_partner_message_page_flag <= (view_next == LPAC_VIEW_NEXT) && word_next[LPAC_BIT_REMOTE_FAULT];
        end
    end
endmodule

// File: lpac_pkg.sv
// shared constants for the link partner ability capture register
package lpac_pkg;
    localparam int          LPAC_ADDR_W          = 5;
    localparam int          LPAC_DATA_W          = 16;
    localparam logic [4:0]  LPAC_PARTNER_ABILITY_ADDR = 5'h05;
    localparam int          LPAC_BIT_NEXT_PAGE   = 15;
    localparam int          LPAC_BIT_ACK         = 14;
    localparam int          LPAC_BIT_REMOTE_FAULT = 13;
    localparam int          LPAC_BIT_RESERVED    = 12;
    localparam int          LPAC_BIT_ASYM_PAUSE  = 11;
    localparam int          LPAC_BIT_PAUSE       = 10;
    localparam int          LPAC_BIT_FOUR_PAIR   = 9;
    localparam int          LPAC_BIT_HUND_FD     = 8;
    localparam int          LPAC_BIT_HUND        = 7;
    localparam int          LPAC_BIT_TEN_FD      = 6;
    localparam int          LPAC_BIT_TEN         = 5;
    localparam int          LPAC_SEL_HI          = 4;
    localparam int          LPAC_SEL_LO          = 0;
    localparam int          LPAC_NP_CODE_HI      = 10;
    localparam logic [15:0] LPAC_RESET_VALUE     = 16'h0000;
    localparam logic [15:0] LPAC_BASE_MASK       = 16'hEFFF;
    localparam logic [15:0] LPAC_NEXT_MASK       = 16'hFFFF;
    localparam logic [15:0] LPAC_ACK_MASK        = 16'h4000;
    typedef enum logic [1:0] {
        LPAC_VIEW_EMPTY,
        LPAC_VIEW_BASE,
        LPAC_VIEW_NEXT
    } lpac_view_t;
endpackage

// File: lpac_partner_ability_properties.sv
// port assertions for the partner ability register
`timescale 1ns/1ps
module lpac_partner_ability_properties (
    input wire logic i_clk, i_rst, i_ce, i_base_valid, i_next_valid, i_ack_seen, i_mgmt_rd, i_mgmt_wr,
    input wire logic [4:0] i_mgmt_addr,
    input wire logic [15:0] i_base_word, o_mgmt_rdata, o_partner_ability_register,
    input wire logic o_mgmt_rvalid, o_partner_next_page, o_partner_remote_fault, o_next_page_view,
    input wire logic o_partner_message_page_flag);
    wire [15:0] w = o_partner_ability_register;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_rd; i_ce && i_mgmt_rd; endsequence
    AST_RVALID: assert property (s_rd |=> o_mgmt_rvalid) else $error("read unanswered");
    AST_RDATA: assert property (s_rd ##0 i_mgmt_addr == 5'h05 |=> o_mgmt_rdata == $past(w)) else $error("bad rdata");
    AST_UNMAPPED: assert property (s_rd ##0 i_mgmt_addr != 5'h05 |=> o_mgmt_rdata == 16'h0000) else $error("bad unmapped");
    AST_RESERVED: assert property (!o_next_page_view |-> !w[12]) else $error("reserved bit set");
    AST_CAPTURE: assert property (i_ce && i_base_valid |=> (w & 16'hAFFF) == ($past(i_base_word) & 16'hAFFF))
        else $error("bad capture");
    AST_ACK: assert property ((i_ce && $stable(i_ack_seen))[*3] |-> w[14] == i_ack_seen) else $error("bad ack");
    AST_FLAGS: assert property (o_partner_next_page == w[15] && (o_next_page_view || o_partner_remote_fault == w[13]))
        else $error("bad flags");
    AST_MSG_FLAG: assert property (o_partner_message_page_flag == (o_next_page_view && w[13]))
        else $error("bad message page flag");
    AST_FREEZE: assert property (!i_ce |=> $stable(w) && $stable(o_mgmt_rdata) && $stable(o_mgmt_rvalid))
        else $error("state moved with clock enable low");
    AST_WRITE: assert property (i_ce && i_mgmt_wr && !i_base_valid && !i_next_valid |=> ((w ^ $past(w)) & 16'hBFFF) == 0)
        else $error("write took effect");
endmodule
bind lpac_partner_ability lpac_partner_ability_properties u_props (.*);

// File: lpac_link_partner.sv
// behavioural remote link partner sending base and next pages
`timescale 1ns/1ps
module lpac_link_partner (
    input  wire logic   i_clk,
    output logic        o_base_valid = 1'b0, o_next_valid = 1'b0, o_an_complete = 1'b0,
    output logic [15:0] o_word = 16'h0000);
    // word lines invert once released so a stale page never looks valid
    task automatic page(input logic nxt, input logic [15:0] w);
        {o_base_valid, o_next_valid, o_word} <= {!nxt, nxt, w};
        @(posedge i_clk);
        {o_base_valid, o_next_valid, o_an_complete, o_word} <= {2'b00, !nxt, ~w};
        @(posedge i_clk) o_an_complete <= 1'b0;
    endtask
endmodule

// File: lpac_partner_ability_tb.sv
// self-checking bench for the partner ability register
`timescale 1ns/1ps
module lpac_partner_ability_tb;
    logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_np_supported = 1'b0, i_ack_seen = 1'b0;
    logic i_mgmt_rd = 1'b0, i_mgmt_wr = 1'b0, i_base_valid, i_next_valid, i_an_complete, o_mgmt_rvalid;
    logic o_partner_next_page, o_partner_remote_fault, o_partner_message_page_flag, o_next_page_view;
    logic [4:0] i_mgmt_addr = 5'h00;
    logic [15:0] i_mgmt_wdata = 16'hFFFF, w, o_mgmt_rdata, o_partner_ability_register;
    int err_total = 0, n_compared = 0;
    initial forever #12.5 i_clk = ~i_clk;
    lpac_link_partner lp (.i_clk(i_clk), .o_base_valid(i_base_valid), .o_next_valid(i_next_valid),
                          .o_an_complete(i_an_complete), .o_word(w));
    lpac_partner_ability uut (.*, .i_base_word(w), .i_next_word(w));
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        {i_mgmt_rd, i_mgmt_addr} <= {1'b1, a};
        @(posedge i_clk) i_mgmt_rd <= 1'b0;
        @(negedge i_clk) n_compared++;
        if (o_mgmt_rvalid !== 1'b1 || o_mgmt_rdata !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, o_mgmt_rdata, exp);
        end
        @(posedge i_clk);
    endtask
    // flags in order: next page, remote fault, message page, next page view
    task automatic flg_chk(input logic [3:0] exp);
        @(negedge i_clk) n_compared++;
        if ({o_partner_next_page, o_partner_remote_fault, o_partner_message_page_flag, o_next_page_view} !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {o_partner_next_page, o_partner_remote_fault,
                     o_partner_message_page_flag, o_next_page_view}, exp);
        end
        @(posedge i_clk);
    endtask
    task automatic test_done;
        $display("compared %0d failed %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_base;
        logic [15:0] pages [3] = '{16'hFFFF, 16'h5A5A, 16'hA5A1};
        {i_mgmt_wr, i_mgmt_addr} <= {1'b1, 5'h05};
        @(posedge i_clk) i_mgmt_wr <= 1'b0;
        rd_chk(5'h05, 16'h0000);
        foreach (pages[k]) begin
            lp.page(1'b0, pages[k]);
            rd_chk(5'h05, pages[k] & 16'hAFFF);
        end
        flg_chk(4'hC);
        rd_chk(5'h04, 16'h0000);
        $display("base done");
    endtask
    task automatic t_next;
        i_ack_seen <= 1'b1;
        lp.page(1'b1, 16'h2123);
        rd_chk(5'h05, 16'hE5A1);
        i_np_supported <= 1'b1;
        lp.page(1'b1, 16'h3456);
        rd_chk(5'h05, 16'h7456);
        flg_chk(4'h3);
        $display("next done");
    endtask
    // a base page offered while the clock enable is low must be lost
    task automatic t_freeze;
        i_ce <= 1'b0;
        lp.page(1'b0, 16'h1234);
        i_ce <= 1'b1;
        @(posedge i_clk);
        rd_chk(5'h05, 16'h7456);
        flg_chk(4'h3);
        $display("freeze done");
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        t_base();
        t_next();
        t_freeze();
        test_done();
    end
endmodule
